// File: verilog/rcmc_pkg.sv
// Package: register map, field positions, reset values and timing for the radio config bank
package rcmc_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_CFG_A  = 3'h0;
  localparam logic [2:0] OFF_CFG_B  = 3'h1;
  localparam logic [2:0] OFF_CFG_C  = 3'h2;
  localparam logic [2:0] OFF_MCTL   = 3'h3;
  localparam logic [2:0] OFF_MSTAT  = 3'h4;
  // Reset values: cfg_b has boot ROM internal, cfg_c has slow clock out and mux1 = port bit
  localparam logic [7:0] RST_CFG_A  = 8'h00;
  localparam logic [7:0] RST_CFG_B  = 8'h02;
  localparam logic [7:0] RST_CFG_C  = 8'h03;
  localparam logic [7:0] RST_MCTL   = 8'h00;
  localparam logic [7:0] RST_MSET   = 8'h00;
  // Writable bit masks; unused bits read zero
  localparam logic [7:0] MASK_CFG_B = 8'h9E;
  localparam logic [7:0] MASK_CFG_C = 8'h77;
  localparam logic [1:0] TONE_NONE  = 2'h3;
  localparam logic [11:0] IFC_SHORT = 12'h100;
  localparam logic [11:0] IFC_LONG  = 12'h980;
  localparam logic [15:0] PROG_TOP  = 16'hFFFF;
  // Data rates in Hz and clock rate in Hz
  localparam int CLK_HZ     = 125000000;
  localparam int RATE_A_HZ  = 10000;
  localparam int RATE_T_HZ  = 8000;
  localparam int HALF_A_CYC = CLK_HZ / (2 * RATE_A_HZ);
  localparam int HALF_T_CYC = CLK_HZ / (2 * RATE_T_HZ);

  typedef struct packed {
    logic       modem_full_enable;
    logic       radio_on_latch_ctl;
    logic       if_counter_start;
    logic       power_off_drive;
    logic       modem_sleep;
    logic       fast_clock_out_sel;
    logic       decoder_sleep;
    logic       if_period_select;
  } rcmc_cfg_a_t;

  typedef struct packed {
    logic       serial_if_sleep;
    logic [1:0] unused_hi;
    logic       decoder_clock_unlock;
    logic       cpu_speed_select;
    logic       tx_tone_source_sel;
    logic       boot_rom_select;
    logic       unused_lo;
  } rcmc_cfg_b_t;

  typedef struct packed {
    logic       unused_hi;
    logic       oscillator_powerdown;
    logic [1:0] output2_bit2_mux;
    logic       unused_mid;
    logic       two_wire_select;
    logic       slow_clock_out_enable;
    logic       output_mux1_sel;
  } rcmc_cfg_c_t;

  typedef struct packed {
    logic       modem_reset_ctl;
    logic       standard_select;
    logic [1:0] tx_tone_code;
    logic       tx_output_enable;
    logic       tracking_loop_mode;
    logic       word_sync_enable;
    logic       channel_type;
  } rcmc_mctl_t;

  typedef struct packed {
    logic       modem_test;
    logic       tx_invert;
    logic       rx_invert;
    logic       discriminator_bypass;
    logic [3:0] squelch_level;
  } rcmc_mset_t;

  // Status coming back from the modem core
  typedef struct packed {
    logic       busy_idle;
    logic [1:0] rx_tone_code;
    logic [3:0] squelch_count;
  } rcmc_mstat_t;
endpackage

// File: verilog/rcmc_top.sv
// Radio configuration ports and modem control/status registers
// Notes on behaviour
// - Modem sleep bit set stops modem clock; clear means modem active.
// - Radio-on clear pulses latch 3; set holds latch 3 high.
// - IF counter start clear holds counter reset; set enables it.
// - IF period select: 256 input periods when clear, 2432 when set.
// - Decoder sleep keeps external program select inactive for address FFFF.
// - Clock unlock clear tracks data clock; set lets recovery clock free-run.
// - Tone source select: local tone when clear, received tone when set.
// - Two-wire select clear holds controller reset; set enables it and pins.
// - Transmit tone code picks 5.97, 6.00, 6.03 kHz; code 11 none.
// - Transmit enable set allows Manchester output; clear disables it.
// - Word sync enable set lets receiver resync; clear disables detection.
// - Transmit invert set inverts transmitted data.
// - Receive invert set inverts discriminator data.
// - Discriminator bypass set bypasses discriminator for test.
// - Squelch level field sets decoder bit quality threshold.
// - Status bit 6 returns latest busy/idle bit.
// - Received tone field reports detected tone; 11 means none.
// - Squelch count gives bits of last word over threshold.
// - Transmit pin carries Manchester data at selected standard rate.
// - Data rate is 10 kHz for AMPS, 8 kHz for TACS.
`timescale 1ns/10ps
module rcmc_top #(
  parameter int HALF_A = rcmc_pkg::HALF_A_CYC,
  parameter int HALF_T = rcmc_pkg::HALF_T_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  input  wire logic [rcmc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [7:0]                  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [7:0]                  rdata_o,
  input  wire rcmc_pkg::rcmc_mstat_t       mstat_i,
  input  wire logic                        tx_bit_i,
  input  wire logic                        rx_tone_in_i,
  input  wire logic                        local_tone_i,
  input  wire logic                        rx_data_i,
  input  wire logic [15:0]                 prog_addr_i,
  input  wire logic                        prog_sel_i,
  output logic                             tx_bit_req_o,
  output logic                             tx_manchester_out_o,
  output logic                             tx_tone_out_o,
  output logic                             modem_clk_en_o,
  output logic                             modem_rst_n_o,
  output logic                             rx_data_o,
  output logic                             latch3_hold_o,
  output logic                             ifc_rst_n_o,
  output logic [11:0]                      ifc_period_o,
  output logic                             ext_prog_chip_select_n_o,
  output logic                             two_wire_rst_n_o,
  output logic                             power_off_out_o,
  output logic                             decoder_clock_unlock_o,
  output logic                             cpu_speed_select_o,
  output rcmc_pkg::rcmc_mctl_t             mctl_o,
  output rcmc_pkg::rcmc_mset_t             mset_o,
  output rcmc_pkg::rcmc_cfg_c_t            cfg_c_o
);

  rcmc_pkg::rcmc_cfg_a_t cfg_a;
  rcmc_pkg::rcmc_cfg_b_t cfg_b;
  rcmc_pkg::rcmc_cfg_c_t cfg_c;
  rcmc_pkg::rcmc_mctl_t  mctl;
  rcmc_pkg::rcmc_mset_t  mset;

  // Received tone, receive data and status inputs pass two flops before use
  logic [1:0] rx_tone_sync;
  logic [1:0] rx_data_sync;
  logic [6:0] stat_sync1;
  logic [6:0] stat_sync2;
  // Status word is taken only when two samples agree, so a torn change never reads back
  logic [6:0] stat_prev;
  logic [6:0] stat_held;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_tone_sync <= 2'h0;
      rx_data_sync <= 2'h0;
      stat_sync1   <= 7'h00;
      stat_sync2   <= 7'h00;
      stat_prev    <= 7'h00;
      stat_held    <= 7'h00;
    end else begin
      rx_tone_sync <= {rx_tone_sync[0], rx_tone_in_i};
      rx_data_sync <= {rx_data_sync[0], rx_data_i};
      stat_sync1   <= mstat_i;
      stat_sync2   <= stat_sync1;
      stat_prev    <= stat_sync2;
      if (stat_sync2 == stat_prev) stat_held <= stat_sync2;
    end
  end

  // Register writes
  wire wr_a = wr_i && (addr_i == rcmc_pkg::OFF_CFG_A);
  wire wr_b = wr_i && (addr_i == rcmc_pkg::OFF_CFG_B);
  wire wr_c = wr_i && (addr_i == rcmc_pkg::OFF_CFG_C);
  wire wr_m = wr_i && (addr_i == rcmc_pkg::OFF_MCTL);
  wire wr_s = wr_i && (addr_i == rcmc_pkg::OFF_MSTAT);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_a <= rcmc_pkg::RST_CFG_A;
      cfg_b <= rcmc_pkg::RST_CFG_B;
      cfg_c <= rcmc_pkg::RST_CFG_C;
      mctl  <= rcmc_pkg::RST_MCTL;
      mset  <= rcmc_pkg::RST_MSET;
    end else begin
      if (wr_a) cfg_a <= wdata_i;
      if (wr_b) cfg_b <= wdata_i & rcmc_pkg::MASK_CFG_B;
      if (wr_c) cfg_c <= wdata_i & rcmc_pkg::MASK_CFG_C;
      if (wr_m) mctl <= wdata_i;
      // test bit held low; software must write zero anyway
      if (wr_s) mset <= {1'b0, wdata_i[6:0]};
    end
  end

  wire [7:0] stat_word = {1'b0, stat_held};
  wire [7:0] next_rdata =
      (addr_i == rcmc_pkg::OFF_CFG_A) ? cfg_a :
      (addr_i == rcmc_pkg::OFF_CFG_B) ? cfg_b :
      (addr_i == rcmc_pkg::OFF_CFG_C) ? cfg_c :
      (addr_i == rcmc_pkg::OFF_MCTL)  ? mctl  :
      (addr_i == rcmc_pkg::OFF_MSTAT) ? stat_word : 8'h00;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) rdata_o <= 8'h00;
    else if (rd_i) rdata_o <= next_rdata;
    else rdata_o <= 8'h00;
  end

  // modem reset release and transmit run; full enable also needed
  wire modem_run = mctl.modem_reset_ctl && cfg_a.modem_full_enable;

  // bit-rate half period select, standard picked by one bit
  logic [15:0] half_cnt;
  logic        phase;
  wire  [15:0] half_lim = mctl.standard_select ? 16'(HALF_A - 1) : 16'(HALF_T - 1);
  wire         half_end = (half_cnt >= half_lim);
  wire         tx_run   = modem_run && !cfg_a.modem_sleep;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_cnt <= 16'h0000;
      phase    <= 1'b0;
    end else if (!tx_run) begin
      half_cnt <= 16'h0000;
      phase    <= 1'b0;
    end else if (half_end) begin
      half_cnt <= 16'h0000;
      phase    <= ~phase;
    end else begin
      half_cnt <= half_cnt + 16'h0001;
    end
  end

  // Manchester encode; bit taken at the start of each bit period
  logic tx_bit;
  wire  bit_start = tx_run && half_end && phase;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) tx_bit <= 1'b0;
    else if (bit_start || !tx_run) tx_bit <= tx_bit_i ^ mset.tx_invert;
  end
  wire next_tx = tx_run && mctl.tx_output_enable && (tx_bit ^ phase);

  // tone source; code 11 silences local tone
  wire local_ok  = (mctl.tx_tone_code != rcmc_pkg::TONE_NONE) && local_tone_i;
  wire next_tone = cfg_b.tx_tone_source_sel ? rx_tone_sync[1] : local_ok;

  // program chip select suppressed at top address while decoder sleep is set
  wire sel_block = cfg_a.decoder_sleep && (prog_addr_i == rcmc_pkg::PROG_TOP);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_manchester_out_o      <= 1'b0;
      tx_bit_req_o             <= 1'b0;
      tx_tone_out_o            <= 1'b0;
      modem_clk_en_o           <= 1'b1;
      modem_rst_n_o            <= 1'b0;
      rx_data_o                <= 1'b0;
      latch3_hold_o            <= 1'b0;
      ifc_rst_n_o              <= 1'b0;
      ifc_period_o             <= rcmc_pkg::IFC_SHORT;
      ext_prog_chip_select_n_o <= 1'b1;
      two_wire_rst_n_o         <= 1'b0;
      power_off_out_o          <= 1'b0;
      decoder_clock_unlock_o   <= 1'b0;
      cpu_speed_select_o       <= 1'b0;
      mctl_o                   <= rcmc_pkg::RST_MCTL;
      mset_o                   <= rcmc_pkg::RST_MSET;
      cfg_c_o                  <= rcmc_pkg::RST_CFG_C;
    end else begin
      tx_manchester_out_o      <= next_tx;
      tx_bit_req_o             <= bit_start;
      tx_tone_out_o            <= next_tone;
      modem_clk_en_o           <= !cfg_a.modem_sleep;
      modem_rst_n_o            <= modem_run;
      // receive path invert; bypass handled by modem core via mset_o
      rx_data_o                <= rx_data_sync[1] ^ mset.rx_invert;
      latch3_hold_o            <= cfg_a.radio_on_latch_ctl;
      ifc_rst_n_o              <= cfg_a.if_counter_start;
      ifc_period_o             <= cfg_a.if_period_select ? rcmc_pkg::IFC_LONG
                                                         : rcmc_pkg::IFC_SHORT;
      ext_prog_chip_select_n_o <= !(prog_sel_i && !sel_block);
      two_wire_rst_n_o         <= cfg_c.two_wire_select;
      power_off_out_o          <= cfg_a.power_off_drive;
      decoder_clock_unlock_o   <= cfg_b.decoder_clock_unlock;
      cpu_speed_select_o       <= cfg_b.cpu_speed_select;
      // control fields passed to modem core
      mctl_o                   <= mctl;
      mset_o                   <= mset;
      cfg_c_o                  <= cfg_c;
    end
  end

  // Assertions
  // Each output except power_off_out_o, cfg_c_o and tx_bit_req_o is checked one cycle after the register state that drives it,
  // since every output is taken straight from a flop

  rd_data_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && addr_i == rcmc_pkg::OFF_CFG_A |=> rdata_o == $past(cfg_a))
    else $error("read data wrong");

  tx_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !mctl.tx_output_enable |=> !tx_manchester_out_o)
    else $error("tx active while disabled");

  sleep_clk_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cfg_a.modem_sleep |=> !modem_clk_en_o)
    else $error("modem clock runs in sleep");

  clk_run_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cfg_a.modem_sleep |=> modem_clk_en_o)
    else $error("modem clock stopped while active");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    latch3_hold_o == $past(cfg_a.radio_on_latch_ctl))
    else $error("latch 3 control wrong");

  ifc_period_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cfg_a.if_period_select |=> ifc_period_o == rcmc_pkg::IFC_LONG)
    else $error("IF period wrong");

  ifc_short_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cfg_a.if_period_select |=> ifc_period_o == rcmc_pkg::IFC_SHORT)
    else $error("IF short period wrong");

  ifc_reset_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cfg_a.if_counter_start |=> !ifc_rst_n_o)
    else $error("IF counter not held");

  ifc_run_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cfg_a.if_counter_start |=> ifc_rst_n_o)
    else $error("IF counter not enabled");

  cs_block_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sel_block |=> ext_prog_chip_select_n_o)
    else $error("chip select at top address");

  cs_pass_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !sel_block |=> ext_prog_chip_select_n_o == !$past(prog_sel_i))
    else $error("chip select not following request");

  unlock_out_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    decoder_clock_unlock_o == $past(cfg_b.decoder_clock_unlock))
    else $error("clock unlock output wrong");

  cpu_speed_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cpu_speed_select_o == $past(cfg_b.cpu_speed_select))
    else $error("cpu speed output wrong");

  tone_src_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cfg_b.tx_tone_source_sel |=> tx_tone_out_o == $past(rx_tone_sync[1]))
    else $error("received tone not routed");

  tone_none_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cfg_b.tx_tone_source_sel && mctl.tx_tone_code == rcmc_pkg::TONE_NONE
    |=> !tx_tone_out_o)
    else $error("tone sent with code none");

  modem_rst_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !mctl.modem_reset_ctl |=> !modem_rst_n_o)
    else $error("modem not held in reset");

  tx_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !mctl.modem_reset_ctl |=> !tx_manchester_out_o)
    else $error("tx active in modem reset");

  tx_req_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_bit_req_o |=> !tx_bit_req_o)
    else $error("bit request longer than one cycle");

  i2c_rst_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cfg_c.two_wire_select |=> !two_wire_rst_n_o)
    else $error("two-wire not held");

  i2c_run_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cfg_c.two_wire_select |=> two_wire_rst_n_o)
    else $error("two-wire not enabled");

  test_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_s |=> !mset.modem_test)
    else $error("test bit set");

  rx_inv_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rx_data_o == ($past(rx_data_sync[1]) ^ $past(mset.rx_invert)))
    else $error("receive data inversion wrong");

  bypass_out_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mset_o.discriminator_bypass == $past(mset.discriminator_bypass))
    else $error("bypass output wrong");

  sq_level_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mset_o.squelch_level == $past(mset.squelch_level))
    else $error("squelch level output wrong");

  word_sync_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mctl_o.word_sync_enable == $past(mctl.word_sync_enable))
    else $error("word sync output wrong");

  chan_type_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mctl_o.channel_type == $past(mctl.channel_type))
    else $error("channel type output wrong");

  busy_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && addr_i == rcmc_pkg::OFF_MSTAT |=> rdata_o[6] == $past(stat_word[6]))
    else $error("busy idle readback wrong");

  tone_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && addr_i == rcmc_pkg::OFF_MSTAT |=> rdata_o[5:4] == $past(stat_word[5:4]))
    else $error("received tone readback wrong");

  sq_count_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && addr_i == rcmc_pkg::OFF_MSTAT |=> rdata_o[3:0] == $past(stat_word[3:0]))
    else $error("squelch count readback wrong");

endmodule // rcmc_top

// File: tb/rcmc_modem_model.sv
// Behavioural modem core and radio pins facing the config bank
`timescale 1ns/10ps
module rcmc_modem_model (
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  input  wire logic [6:0]      stat_i,
  input  wire logic [2:0]      lines_i,
  input  wire logic            bit_i,
  output rcmc_pkg::rcmc_mstat_t mstat_o,
  output logic                 tx_bit_o,
  output logic                 rx_tone_o,
  output logic                 local_tone_o,
  output logic                 rx_data_o
);
  // Status is registered on the same clock as the bank, so the bank sees it as a synchronous source
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mstat_o  <= '0;
      tx_bit_o <= 1'h0;
    end else begin
      mstat_o  <= stat_i;
      tx_bit_o <= bit_i;
    end
  end
  assign rx_tone_o    = lines_i[2];
  assign local_tone_o = lines_i[1];
  assign rx_data_o    = lines_i[0];
endmodule // rcmc_modem_model

// File: tb/tb.sv
// Self-checking bench for the radio config and modem control bank
`timescale 1ns/10ps
module tb;
  logic                  clk, nrst, wr, rd, psel, tbit, txbit, rxtone, ltone, rxd;
  logic                  req, txo, toneo, clken, mrstn, rxo, l3, ifcrn, csn, twrn, poff, unl, cpu;
  logic [2:0]            addr, lines;
  logic [7:0]            wdata, rdata;
  logic [6:0]            stat;
  logic [11:0]           ifcp;
  logic [15:0]           paddr;
  rcmc_pkg::rcmc_mstat_t mstat;
  rcmc_pkg::rcmc_mctl_t  mctl;
  rcmc_pkg::rcmc_mset_t  mset;
  rcmc_pkg::rcmc_cfg_c_t cfgc;
  int                    n_mismatch, checked, n;
  logic                  s0;

  rcmc_top #(.HALF_A(4), .HALF_T(5)) rcmc_top_i (
    .clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .mstat_i(mstat), .tx_bit_i(txbit), .rx_tone_in_i(rxtone),
    .local_tone_i(ltone), .rx_data_i(rxd), .prog_addr_i(paddr), .prog_sel_i(psel),
    .tx_bit_req_o(req), .tx_manchester_out_o(txo), .tx_tone_out_o(toneo),
    .modem_clk_en_o(clken), .modem_rst_n_o(mrstn), .rx_data_o(rxo), .latch3_hold_o(l3),
    .ifc_rst_n_o(ifcrn), .ifc_period_o(ifcp), .ext_prog_chip_select_n_o(csn),
    .two_wire_rst_n_o(twrn), .power_off_out_o(poff), .decoder_clock_unlock_o(unl),
    .cpu_speed_select_o(cpu), .mctl_o(mctl), .mset_o(mset), .cfg_c_o(cfgc));

  rcmc_modem_model rcmc_modem_model_i (
    .clk_i(clk), .nrst_i(nrst), .stat_i(stat), .lines_i(lines), .bit_i(tbit),
    .mstat_o(mstat), .tx_bit_o(txbit), .rx_tone_o(rxtone), .local_tone_o(ltone),
    .rx_data_o(rxd));

  task automatic test_done;
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk(rdata, e);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Bounded hunt for the next bit-start pulse; n is cycles waited in this call, the pulse spacing when called right after one
  task automatic wait_req;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (req !== 1'h1 && n < 60);
    if (n >= 60) begin
      n_mismatch++;
      test_done();
    end
  endtask

  task automatic t_reset;
    rchk(3'h0, 8'h00);
    rchk(3'h1, 8'h02);
    rchk(3'h2, 8'h03);
    rchk(3'h3, 8'h00);
    chk(ifcp, 12'h100);
    wreg(3'h5, 8'hFF);
    rchk(3'h5, 8'h00);
  endtask
  task automatic t_cfg;
    wreg(3'h0, 8'hFF);
    settle(2);
    chk(l3, 12'h1);
    chk(ifcrn, 12'h1);
    chk(ifcp, 12'h980);
    chk(clken, 12'h0);
    chk(poff, 12'h1);
    wreg(3'h0, 8'h00);
    settle(2);
    chk({l3, ifcrn, clken, poff}, 12'h2);
    chk(ifcp, 12'h100);
    wreg(3'h1, 8'hFF);
    rchk(3'h1, 8'h9E);
    chk({unl, cpu}, 12'h3);
    wreg(3'h1, 8'h02);
    wreg(3'h2, 8'hFF);
    rchk(3'h2, 8'h77);
    chk(cfgc, 12'h77);
    chk(twrn, 12'h1);
    wreg(3'h2, 8'h03);
    settle(2);
    chk({twrn, unl, cpu}, 12'h0);
  endtask
  task automatic t_cs;
    @(posedge clk) paddr <= 16'hFFFF;
    psel <= 1'h1;
    wreg(3'h0, 8'h02);
    settle(3);
    chk(csn, 12'h1);
    @(posedge clk) paddr <= 16'h1234;
    settle(3);
    chk(csn, 12'h0);
    @(posedge clk) paddr <= 16'hFFFF;
    wreg(3'h0, 8'h00);
    settle(3);
    chk(csn, 12'h0);
  endtask
  task automatic t_mux;
    @(posedge clk) lines <= 3'h2;
    wreg(3'h3, 8'h00);
    settle(5);
    chk(toneo, 12'h1);
    wreg(3'h3, 8'h30);
    settle(3);
    chk(toneo, 12'h0);
    wreg(3'h1, 8'h06);
    @(posedge clk) lines <= 3'h5;
    settle(6);
    chk({toneo, rxo}, 12'h3);
    // Tone source and rx data are both synced, so allow the sync stages
    wreg(3'h4, 8'h20);
    settle(3);
    chk(rxo, 12'h0);
    wreg(3'h4, 8'h75);
    settle(2);
    chk(mset, 12'h75);
    wreg(3'h4, 8'h00);
    wreg(3'h1, 8'h02);
  endtask
  task automatic t_status;
    @(posedge clk) stat <= 7'h6A;
    settle(6);
    rchk(3'h4, 8'h6A);
    @(posedge clk) stat <= 7'h35;
    settle(6);
    rchk(3'h4, 8'h35);
  endtask
  task automatic t_tx;
    wreg(3'h0, 8'h80);
    wreg(3'h3, 8'hC8);
    settle(2);
    chk(mrstn, 12'h1);
    wait_req();
    wait_req();
    chk(n, 12'h8);
    settle(2);
    s0 = txo;
    settle(4);
    chk(txo, {11'h0, ~s0});
    wreg(3'h4, 8'h40);
    wait_req();
    wait_req();
    settle(2);
    chk(txo, {11'h0, ~s0});
    wreg(3'h3, 8'h88);
    wait_req();
    wait_req();
    chk(n, 12'hA);
    chk(mctl, 12'h88);
    wreg(3'h3, 8'h80);
    settle(2);
    repeat (10) begin
      settle(1);
      chk(txo, 12'h0);
    end
    wreg(3'h0, 8'h00);
    settle(2);
    chk(mrstn, 12'h0);
  endtask

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    {nrst, wr, rd, psel, addr, wdata, stat, lines, paddr} = '0;
    tbit = 1'h1;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    t_reset();
    t_cfg();
    t_cs();
    t_mux();
    t_status();
    t_tx();
    test_done();
  end
endmodule // tb
